// >>> irc_pkg.sv
// Constants, types and reset values of the infrared remote frame decoder
//----------------------------------------------------------------------
// Overview of operation
// [RL1] A frame is fourteen bits, collected in transmission order first.
// [RL2] The two first bits are start bits sent as one; they open a frame.
// [RL3] Third bit is the toggle bit, inverted per key press; report it.
// [RL4] Five bits after the toggle bit form the system address output.
// [RL5] The last six bits form the command field, 64 values per address.
// [RL6] Each bit comes from the mid-cell transition of its bi-phase cell.
// [RL7] With extended frames the extended bit sits at command bit 6.
// [RL8] The toggle bit sits at command bit 7 beside command and extension.
// [RL9] The consumer acts only on frames carrying its own system address.
// [RL10] A dedicated timer paces all bit-cell sampling and nothing else.
// [RL11] After bit fourteen, outputs update together with a one-cycle strobe.
// [RL12] Missing mid-cell transition or zero start bit discards the frame; the code keeps a zero second start bit when ctl_ext is set.
//----------------------------------------------------------------------
package irc_pkg;

    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int HALF_BIT_NS = 889_000;
    localparam int HALF_BIT_CYC = HALF_BIT_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 16;

    //------------------------------------------------------------------
    // Frame layout, first received bit is the most significant
    //------------------------------------------------------------------
    localparam int FRAME_BITS = 14;
    localparam int POS_START1 = 13;
    localparam int POS_START2 = 12;
    localparam int POS_TOGGLE = 11;
    localparam int POS_ADDR = 6;
    localparam int ADDR_W = 5;
    localparam int CMD_W = 6;
    localparam int OUT_CMD_W = 8;
    localparam int CMD_EXT_BIT = 6;
    localparam int CMD_TOG_BIT = 7;
    localparam logic [4:0] LAST_SAMPLE = 5'h1a;

    //------------------------------------------------------------------
    // Register map, byte addresses on the bus
    //------------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_FRAME = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SEEN_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int FRAME_CMD_LSB = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } irc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [OUT_CMD_W-1:0] cmd;
    } irc_frame_s;

    typedef struct packed {
        irc_state_e fsm;
        logic rx_s1;
        logic rx_s2;
        logic rx_d;
        logic [TMR_W-1:0] tmr;
        logic [4:0] smp;
        logic first_half;
        logic [FRAME_BITS-2:0] shreg;
        irc_frame_s frame;
        logic valid;
        logic ctl_en;
        logic ctl_ext;
        logic seen;
        logic err;
        logic dp_wr;
        logic [3:0] dp_addr;
        logic [31:0] rdata;
        logic ready;
    } irc_regs_s;

    localparam irc_regs_s REGS_RST = '{
        fsm: ST_IDLE, rx_s1: 1'b1, rx_s2: 1'b1, rx_d: 1'b1,
        tmr: 16'h0000, smp: 5'h00, first_half: 1'b0,
        shreg: 13'h0000, frame: '0, valid: 1'b0,
        ctl_en: 1'b1, ctl_ext: 1'b0, seen: 1'b0, err: 1'b0,
        dp_wr: 1'b0, dp_addr: 4'h0, rdata: 32'h0000_0000, ready: 1'b1
    };

endpackage : irc_pkg

// >>> irc_rc5_decoder.sv
// Bi-phase remote frame decoder with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none

module irc_rc5_decoder
    import irc_pkg::*;
#(
    parameter int HALF_CYC = HALF_BIT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ir_rx_n,
    output var irc_frame_s rc_frame,
    output logic frame_valid
);

    //------------------------------------------------------------------
    // Timer reloads
    //------------------------------------------------------------------
    // The first sample waits a quarter bit past the opening edge so that
    // every later sample lands mid-way in a half cell, away from edges.
    localparam logic [TMR_W-1:0] RELOAD_Q = TMR_W'(HALF_CYC / 2 - 1);
    localparam logic [TMR_W-1:0] RELOAD_H = TMR_W'(HALF_CYC - 1);

    irc_regs_s st_ff;
    irc_regs_s nxt_st;

    logic fall;
    logic tick;
    logic addr_ok;
    logic cur_bit;
    logic [FRAME_BITS-1:0] full;
    logic err_ev;

    always_comb begin
        fall = st_ff.rx_d & ~st_ff.rx_s2;
        tick = (st_ff.fsm == ST_RUN) && (st_ff.tmr == '0);
        addr_ok = hsel && htrans[1] && hready;
        cur_bit = st_ff.first_half;
        full = {st_ff.shreg, cur_bit};
    end

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        nxt_st.ready = 1'b1;
        err_ev = 1'b0;

        // Pin synchroniser; the second stage and its delayed copy rx_d feed logic
        nxt_st.rx_s1 = ir_rx_n;
        nxt_st.rx_s2 = st_ff.rx_s1;
        nxt_st.rx_d = st_ff.rx_s2;

        case (st_ff.fsm)
            ST_IDLE: begin
                // Idle line is high; the fall is the middle of start bit one
                if (st_ff.ctl_en && fall) begin
                    nxt_st.fsm = ST_RUN; // RL2
                    nxt_st.tmr = RELOAD_Q; // RL10
                    nxt_st.smp = 5'h00;
                    nxt_st.shreg = 13'h0001; // RL1
                end
            end
            ST_RUN: begin
                if (!st_ff.ctl_en) begin
                    nxt_st.fsm = ST_IDLE;
                end else if (!tick) begin
                    nxt_st.tmr = st_ff.tmr - 16'h0001; // RL10
                end else begin
                    nxt_st.tmr = RELOAD_H; // RL10
                    nxt_st.smp = st_ff.smp + 5'h01;
                    if (st_ff.smp == 5'h00) begin
                        // Second half of start bit one must carry
                        if (st_ff.rx_s2) begin
                            nxt_st.fsm = ST_IDLE; // RL12
                            nxt_st.err = 1'b1;
                            err_ev = 1'b1;
                        end
                    end else if (st_ff.smp[0]) begin
                        nxt_st.first_half = st_ff.rx_s2; // RL6
                    end else if (st_ff.rx_s2 == st_ff.first_half) begin
                        nxt_st.fsm = ST_IDLE; // RL12
                        nxt_st.err = 1'b1;
                        err_ev = 1'b1;
                    end else if (st_ff.smp == 5'h02 && !st_ff.first_half
                                 && !st_ff.ctl_ext) begin
                        // Zero second start bit is legal only when extended
                        nxt_st.fsm = ST_IDLE; // RL12
                        nxt_st.err = 1'b1;
                        err_ev = 1'b1;
                    end else if (st_ff.smp == LAST_SAMPLE) begin
                        nxt_st.fsm = ST_IDLE;
                        nxt_st.frame.addr = full[POS_ADDR +: ADDR_W]; // RL4
                        nxt_st.frame.cmd[CMD_W-1:0] = full[CMD_W-1:0]; // RL5
                        nxt_st.frame.cmd[CMD_EXT_BIT] =
                            st_ff.ctl_ext & ~full[POS_START2]; // RL7
                        nxt_st.frame.cmd[CMD_TOG_BIT] =
                            full[POS_TOGGLE]; // RL8 RL3
                        nxt_st.valid = 1'b1; // RL11
                        nxt_st.seen = 1'b1;
                    end else begin
                        // High first half then low second half is a one
                        nxt_st.shreg = {st_ff.shreg[FRAME_BITS-3:0],
                                        st_ff.first_half}; // RL6 RL1
                    end
                end
            end
            default: begin
                nxt_st.fsm = ST_IDLE;
            end
        endcase

        //--------------------------------------------------------------
        // Bus data phase; sticky clears are skipped on a same-cycle set
        // from the decoder above so that set is not lost
        //--------------------------------------------------------------
        if (st_ff.dp_wr) begin
            case (st_ff.dp_addr)
                OFS_CTRL: begin
                    nxt_st.ctl_en = hwdata[CTRL_EN_BIT];
                    nxt_st.ctl_ext = hwdata[CTRL_EXT_BIT];
                end
                OFS_STATUS: begin
                    if (hwdata[STAT_SEEN_BIT] && !nxt_st.valid) begin
                        nxt_st.seen = 1'b0;
                    end
                    // Set wins even when the flag is already high
                    if (hwdata[STAT_ERR_BIT] && !err_ev) begin
                        nxt_st.err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Bus address phase; read data is prepared for the next cycle
        nxt_st.dp_wr = addr_ok && hwrite;
        nxt_st.dp_addr = haddr[3:0];
        nxt_st.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr[3:0])
                OFS_CTRL: begin
                    nxt_st.rdata[CTRL_EN_BIT] = st_ff.ctl_en;
                    nxt_st.rdata[CTRL_EXT_BIT] = st_ff.ctl_ext;
                end
                OFS_STATUS: begin
                    nxt_st.rdata[STAT_BUSY_BIT] = (st_ff.fsm == ST_RUN);
                    nxt_st.rdata[STAT_SEEN_BIT] = st_ff.seen;
                    nxt_st.rdata[STAT_ERR_BIT] = st_ff.err;
                end
                OFS_FRAME: begin
                    nxt_st.rdata[ADDR_W-1:0] = st_ff.frame.addr;
                    nxt_st.rdata[FRAME_CMD_LSB +: OUT_CMD_W] = st_ff.frame.cmd;
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= REGS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Frame outputs hold between strobes; consumers filter on address
    assign rc_frame = st_ff.frame; // RL11 RL9
    assign frame_valid = st_ff.valid;
    assign hrdata = st_ff.rdata;
    assign hreadyout = st_ff.ready;
    assign hresp = 1'b0 & st_ff.ready;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_strobe_single;
        frame_valid |=> !frame_valid ##1 !frame_valid;
    endproperty
    a_strobe_single: assert property (p_strobe_single) // RL11
        else $error("frame strobe longer than one cycle");

    property p_len;
        frame_valid |-> $past(st_ff.smp) == LAST_SAMPLE;
    endproperty
    a_len: assert property (p_len) // RL1
        else $error("frame completed at wrong bit count");

    property p_start;
        frame_valid |-> $past(st_ff.shreg[POS_START1-1]);
    endproperty
    a_start: assert property (p_start) // RL2
        else $error("frame accepted without leading start bit");

    property p_addr;
        frame_valid |-> rc_frame.addr == $past(st_ff.shreg[POS_ADDR-1 +: ADDR_W]);
    endproperty
    a_addr: assert property (p_addr) // RL4
        else $error("address field misplaced");

    property p_cmd;
        frame_valid |-> rc_frame.cmd[CMD_W-1:0] ==
            {$past(st_ff.shreg[CMD_W-2:0]), $past(st_ff.first_half)};
    endproperty
    a_cmd: assert property (p_cmd) // RL5
        else $error("command field misplaced");

    property p_ext;
        frame_valid |-> rc_frame.cmd[CMD_EXT_BIT] ==
            ($past(st_ff.ctl_ext) & ~$past(st_ff.shreg[POS_START2-1]));
    endproperty
    a_ext: assert property (p_ext) // RL7
        else $error("extended bit misplaced");

    property p_tog;
        frame_valid |-> rc_frame.cmd[CMD_TOG_BIT] ==
            $past(st_ff.shreg[POS_TOGGLE-1]);
    endproperty
    a_tog: assert property (p_tog) // RL8
        else $error("toggle bit misplaced");

    property p_pace;
        (st_ff.fsm == ST_RUN && $past(st_ff.fsm) == ST_RUN
            && st_ff.smp != $past(st_ff.smp))
            |-> $past(st_ff.tmr) == '0 && st_ff.tmr == RELOAD_H;
    endproperty
    a_pace: assert property (p_pace) // RL10
        else $error("sample taken off the timer event");

    property p_no_mid;
        (tick && st_ff.smp != 5'h00 && !st_ff.smp[0]
            && st_ff.rx_s2 == st_ff.first_half && st_ff.ctl_en)
            |=> st_ff.fsm == ST_IDLE && !frame_valid ##1 !frame_valid;
    endproperty
    a_no_mid: assert property (p_no_mid) // RL12 RL6
        else $error("cell without transition not discarded");

    property p_start_zero;
        (tick && st_ff.smp == 5'h00 && st_ff.rx_s2 && st_ff.ctl_en)
            |=> st_ff.fsm == ST_IDLE && st_ff.err;
    endproperty
    a_start_zero: assert property (p_start_zero) // RL12
        else $error("zero start bit not discarded");

    property p_hold;
        !frame_valid |-> $stable(rc_frame);
    endproperty
    a_hold: assert property (p_hold) // RL11
        else $error("frame outputs changed without strobe");

    property p_valid_idle;
        frame_valid |-> st_ff.fsm == ST_IDLE && st_ff.seen;
    endproperty
    a_valid_idle: assert property (p_valid_idle) // RL11
        else $error("strobe while busy or seen flag not set");

    property p_err_set_wins;
        err_ev |=> st_ff.err;
    endproperty
    a_err_set_wins: assert property (p_err_set_wins) // RL12
        else $error("discard did not leave error flag set");

    property p_first_wait;
        (st_ff.fsm == ST_RUN && $past(st_ff.fsm) == ST_IDLE)
            |-> st_ff.tmr == RELOAD_Q && st_ff.smp == 5'h00;
    endproperty
    a_first_wait: assert property (p_first_wait) // RL10
        else $error("frame start without quarter bit timer load");

    property p_tmr_count;
        (st_ff.fsm == ST_RUN && $past(st_ff.fsm) == ST_RUN && !$past(tick))
            |-> st_ff.tmr == $past(st_ff.tmr) - 16'h0001;
    endproperty
    a_tmr_count: assert property (p_tmr_count) // RL10
        else $error("bit timer did not count down");

    property p_bit_count;
        st_ff.fsm == ST_RUN |-> st_ff.smp <= LAST_SAMPLE;
    endproperty
    a_bit_count: assert property (p_bit_count) // RL1
        else $error("frame ran past its last sample");

    property p_no_start;
        (st_ff.fsm == ST_IDLE && !(st_ff.ctl_en && fall))
            |=> st_ff.fsm == ST_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) // RL2
        else $error("frame opened without a start edge");

endmodule : irc_rc5_decoder

`default_nettype wire

// >>> irc_ir_tx.sv
// Model of the infrared receiver module that feeds the decoder pin
`timescale 1ns/10ps
`default_nettype none

module irc_ir_tx (
    input wire logic hclk,
    output logic ir_rx_n
);
    // The receiver output is pulled up, so a quiet line reads high
    initial ir_rx_n = 1'b1;

    //------------------------------------------------------------------
    // Frame sender
    //------------------------------------------------------------------
    // Sends first bit first; the cell at index bad keeps its level
    task automatic send(input logic [13:0] f, input int bad, input int half);
        for (int i = 13; i >= 0; i--) begin
            ir_rx_n <= f[i];
            repeat (half) @(posedge hclk);
            ir_rx_n <= (i == bad) ? f[i] : ~f[i];
            repeat (half) @(posedge hclk);
        end
        ir_rx_n <= 1'b1;
    endtask : send

    // A short low pulse with no frame behind it
    task automatic glitch(input int len);
        ir_rx_n <= 1'b0;
        repeat (len) @(posedge hclk);
        ir_rx_n <= 1'b1;
    endtask : glitch
endmodule : irc_ir_tx
`default_nettype wire

// >>> ir_rc5_frame_decoder_tb.sv
// Self-checking bench of the infrared remote frame decoder
`timescale 1ns/10ps
`default_nettype none

module ir_rc5_frame_decoder_tb;
    import irc_pkg::*;
    // Short half-bit keeps each frame near 450 cycles
    localparam int H = 16;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic ir_rx_n, frame_valid, ext;
    logic [31:0] haddr, hwdata, hrdata, rnd, scr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    irc_frame_s rc_frame, last;
    irc_frame_s exp_q[$];
    int n_fail = 0;
    int n_tests = 0;
    localparam logic [4:0] OWN_ADDR = 5'h00;
    int n_own = 0;
    int exp_own = 0;

    assign hready = hreadyout;
    irc_ir_tx tx (.hclk(hclk), .ir_rx_n(ir_rx_n));
    irc_rc5_decoder #(.HALF_CYC(H)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ir_rx_n(ir_rx_n), .rc_frame(rc_frame),
        .frame_valid(frame_valid)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : check

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {28'h0000_000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        check({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : bus

    // Idle cycle after a write so a following read sees the new value
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, scr);
        @(posedge hclk);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, lfsr(rnd), d);
        check(d, e);
    endtask : rd_chk

    task automatic frame(input logic [13:0] f, input int bad, input logic ok);
        irc_frame_s e;
        e.addr = f[10:6];
        e.cmd = {f[11], ext & ~f[12], f[5:0]};
        if (ok) begin
            exp_q.push_back(e);
            last = e;
            if (e.addr == OWN_ADDR)
                exp_own++;
        end
        tx.send(f, bad, H);
        repeat (4 * H) @(posedge hclk);
        check(32'(exp_q.size()), 32'h0000_0000);
    endtask : frame

    //------------------------------------------------------------------
    // Output monitor
    //------------------------------------------------------------------
    always @(posedge hclk) begin
        if (frame_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check(32'h0000_0001, 32'h0000_0000);
            else
                check({19'h0, rc_frame}, {19'h0, exp_q.pop_front()});
        end
        if (frame_valid === 1'b1 && rc_frame.addr == OWN_ADDR)
            n_own++;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        n_fail++;
        end_sim;
    end

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        hsize = 3'b010;
        ext = 1'b0;
        rnd = 32'h5d8f_4548;
        last = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd_chk(OFS_CTRL, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr(OFS_FRAME, 32'hffff_ffff);
        rd_chk(OFS_FRAME, 32'h0000_0000);
        wr(4'hc, 32'hffff_ffff);
        rd_chk(4'hc, 32'h0000_0000);
        $display("test registers done");
        // Start bits one, then all-ones, all-zeros and six random toggle, address and command fields
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            frame({2'b11, (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : rnd[11:0]},
                  -1, 1'b1);
        end
        rd_chk(OFS_FRAME, {16'h0000, last.cmd, 3'h0, last.addr});
        rd_chk(OFS_STATUS, 32'h0000_0002);
        wr(OFS_STATUS, 32'h0000_0002);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        $display("test frames done");
        wr(OFS_CTRL, 32'h0000_0003);
        ext = 1'b1;
        frame({2'b10, rnd[23:12]}, -1, 1'b1);
        frame({2'b11, rnd[23:12]}, -1, 1'b1);
        wr(OFS_STATUS, 32'h0000_0006);
        $display("test extended done");
        // A cell without its mid-cell transition drops the frame
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            frame({2'b11, rnd[11:0]}, 12 - 6 * i, 1'b0);
            rd_chk(OFS_STATUS, 32'h0000_0004);
            wr(OFS_STATUS, 32'h0000_0004);
        end
        wr(OFS_CTRL, 32'h0000_0001);
        ext = 1'b0;
        frame({2'b10, rnd[11:0]}, -1, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_0004);
        wr(OFS_STATUS, 32'h0000_0004);
        tx.glitch(H / 4);
        repeat (2 * H) @(posedge hclk);
        rd_chk(OFS_STATUS, 32'h0000_0004);
        wr(OFS_STATUS, 32'h0000_0004);
        $display("test discard done");
        wr(OFS_CTRL, 32'h0000_0000);
        frame({2'b11, rnd[11:0]}, -1, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        fork
            frame({2'b11, rnd[27:16]}, -1, 1'b1);
            begin
                repeat (8 * H) @(posedge hclk);
                rd_chk(OFS_STATUS, 32'h0000_0001);
            end
        join
        $display("test enable and busy done");
        check(n_own, exp_own);
        end_sim;
    end
endmodule : ir_rc5_frame_decoder_tb
`default_nettype wire
